// File: src/cache_mode_policy_control.sv
// Top of the cache policy control: registers, mode decode and per-access decisions.
// Summary of operation
// - Both global flags set: read hits served, read misses never allocate or replace.
// - Same mode: write hit updates line, exclusive goes modified, misses go to memory.
// - Same mode: snoops never invalidate; discard and writeback-discard still invalidate.
// - Same mode: outer caches serve external snoops, first-level cache does not.
// - Older variants leave reset with both global flags set.
// - Newer variants: cache-off set means no-fill mode, write-policy flag ignored.
// - Low-power variant: cache-off set disables caching completely.
// - Write-policy flag is bit 29; both flags clear gives normal mode, type set by page and range.
// - Older variant, L1 disabled: snoops accepted when dual, inhibited when single.
// - Inhibited snoops skip parity check; accepted snoops flag corrupt addresses.
// - Page cache-off flag blocks caching; only with paging on, cache-off clear.
// - Page write-through flag picks write-through; only with paging on, policy clear.
// - Page-base flags govern the page directory only, under the same conditions as the page flags.
// - Sticky entries survive flushes only while sticky enable set; established only while sticky enable set.
// - Miscellaneous bit 6 switches the third-level cache independently.
// - Page flag pins follow the selected page flags for the external cache.
// - Range table assigns a memory type to each physical region.
// - Whichever of page or range control forbids caching wins.
// - Write-back against write-through resolves to write-through.
`default_nettype none
module cache_mode_policy_control
	import cache_policy_pkg::*;
(
	input  wire logic                                      core_clk,
	input  wire logic                                      srst,
	input  wire logic [cache_policy_pkg::REG_ADDR_W-1:0]   reg_addr,
	input  wire logic [cache_policy_pkg::REG_DATA_W-1:0]   reg_wdata,
	input  wire logic                                      reg_write,
	input  wire logic                                      reg_read,
	output logic      [cache_policy_pkg::REG_DATA_W-1:0]   reg_rdata,
	input  wire logic                                      access_valid,
	input  wire logic                                      access_write,
	input  wire logic                                      access_dir,
	input  wire logic [31:0]                               access_addr,
	input  wire logic                                      access_hit,
	input  wire cache_policy_pkg::line_state_t             access_line_state,
	input  wire logic                                      pte_cache_off,
	input  wire logic                                      pte_write_thru,
	input  wire logic                                      pte_sticky,
	input  wire logic                                      cacheable_access_input_n,
	input  wire logic                                      writeback_select_input,
	input  wire logic                                      snoop_valid,
	input  wire logic [31:0]                               snoop_addr,
	input  wire logic                                      snoop_addr_parity,
	input  wire logic                                      snoop_hit,
	input  wire logic                                      snoop_invalidating,
	input  wire logic                                      discard_all_lines_op,
	input  wire logic                                      writeback_discard_op,
	input  wire logic                                      tlb_flush_req,
	input  wire logic                                      tlb_entry_sticky,
	output logic                                           resp_valid,
	output logic                                           resp_serve_from_cache,
	output logic                                           resp_allocate,
	output logic                                           resp_update_line,
	output logic                                           resp_write_memory,
	output cache_policy_pkg::line_state_t                  resp_next_state,
	output cache_policy_pkg::mem_type_t                    resp_mem_type,
	output logic                                           resp_l3_allocate,
	output logic                                           resp_sticky_ok,
	output logic                                           page_cache_off_pin,
	output logic                                           page_write_thru_pin,
	output logic                                           snoop_l1_invalidate,
	output logic                                           snoop_outer_forward,
	output logic                                           addr_parity_error_out_n,
	output logic                                           l1_discard_all,
	output logic                                           l1_writeback_discard,
	output logic                                           tlb_flush_entry
);
	import cache_policy_pkg::*;

	typedef struct packed {
		logic [31:0]                   ctrl_zero;
		logic                          pb_cache_off;
		logic                          pb_write_thru;
		logic                          sticky_enable;
		logic                          l3_off;
		variant_t                      variant;
		logic                          dual;
		logic                          l3_present;
		logic [RANGE_COUNT-1:0][31:0]  range;
		logic [2:0]                    ken_sync;
		logic [2:0]                    wbs_sync;
		logic                          ken_cacheable;
		logic                          wb_select;
		logic [31:0]                   rdata;
		logic                          resp_valid;
		logic                          serve;
		logic                          alloc;
		logic                          update;
		logic                          wmem;
		line_state_t                   next_state;
		mem_type_t                     eff_type;
		logic                          l3_alloc;
		logic                          sticky_ok;
		logic                          pin_cache_off;
		logic                          pin_write_thru;
		logic                          snoop_inval;
		logic                          snoop_outer;
		logic                          parity_err_n;
		logic                          discard;
		logic                          wb_discard;
		logic                          flush_entry;
	} state_t;

	state_t st;
	state_t next_st;

	policy_if pif ();

	mem_type_combiner u_combiner (
		.pif (pif)
	);

	logic        [RANGE_COUNT-1:0] range_hit;
	mem_type_t   [RANGE_COUNT-1:0] range_type;

	// Each region matches on the upper address bits; invalid codes fall back to uncached.
	genvar gi;
	generate
		for (gi = 0; gi < RANGE_COUNT; gi++) begin : g_range
			assign range_hit[gi] = st.range[gi][RANGE_VALID_BIT]
				&& st.range[gi][RANGE_BASE_LSB +: RANGE_BASE_W]
				== access_addr[RANGE_BASE_LSB +: RANGE_BASE_W];
			assign range_type[gi] =
				(st.range[gi][RANGE_TYPE_LSB +: RANGE_TYPE_W] > MT_WB)
				? MT_UC : mem_type_t'(st.range[gi][RANGE_TYPE_LSB +: RANGE_TYPE_W]);
		end
	endgenerate

	logic        cache_off;
	logic        write_policy;
	logic        paging;
	cache_mode_t mode;
	mem_type_t   region_type;
	mem_type_t   eff;
	logic        sel_cache_off;
	logic        sel_write_thru;
	logic        line_present;
	logic        cacheable;
	logic        l1_snoop_service;
	logic        snoop_accept;
	logic        range_sel;

	always_comb begin
		cache_off    = st.ctrl_zero[CTRL0_CACHE_OFF_BIT];
		write_policy = st.ctrl_zero[CTRL0_WRITE_POLICY_BIT];
		paging       = st.ctrl_zero[CTRL0_PAGING_BIT];
		if (!cache_off) begin
			mode = MODE_NORMAL;
		end else begin
			unique case (st.variant)
				VAR_OLDER:     mode = write_policy ? MODE_NONCOHERENT : MODE_NO_FILL;
				VAR_NEWER:     mode = MODE_NO_FILL;
				VAR_LOW_POWER: mode = MODE_DISABLED;
				default:       mode = MODE_DISABLED;
			endcase
		end
	end

	always_comb begin
		// Directory walks take the page-base flags, page accesses their own entry flags.
		sel_cache_off  = access_dir ? st.pb_cache_off : pte_cache_off;
		sel_write_thru = access_dir ? st.pb_write_thru : pte_write_thru;
		region_type = RANGE_DEFAULT_TYPE;
		for (int i = RANGE_COUNT - 1; i >= 0; i--) begin
			if (range_hit[i]) begin
				region_type = range_type[i];
			end
		end
		// The older variant has no range table; the external pins decide per area.
		if (st.variant == VAR_OLDER) begin
			if (!st.ken_cacheable) begin
				region_type = MT_UC;
			end else begin
				region_type = st.wb_select ? MT_WB : MT_WT;
			end
		end
	end

	assign pif.range_type         = region_type;
	assign pif.page_cache_off     = sel_cache_off;
	assign pif.page_write_thru    = sel_write_thru;
	assign pif.cache_off_applies  = paging && !cache_off;
	assign pif.write_thru_applies = paging && !write_policy;
	assign eff                    = pif.eff_type;

	always_comb begin
		l1_snoop_service = (mode == MODE_NORMAL) || (mode == MODE_NO_FILL);
		// A single-processor system running with L1 off need not watch the bus at all.
		snoop_accept = !(st.variant == VAR_OLDER && mode == MODE_NONCOHERENT
			&& !st.dual);
		line_present = access_hit && access_line_state != LINE_I;
		cacheable    = eff != MT_UC && eff != MT_WC;
		range_sel    = reg_addr[RANGE_AREA_LSB +: RANGE_IDX_W + RANGE_IDX_W] == RANGE_AREA_TAG
			&& reg_addr[1:0] == WORD_ALIGN;
	end

	always_comb begin
		next_st = st;

		if (reg_write) begin
			unique case (reg_addr)
				OFS_CTRL_ZERO: next_st.ctrl_zero = reg_wdata;
				OFS_PAGE_BASE: begin
					next_st.pb_cache_off  = reg_wdata[PAGE_BASE_CO_BIT];
					next_st.pb_write_thru = reg_wdata[PAGE_BASE_WT_BIT];
				end
				OFS_CTRL_FOUR: next_st.sticky_enable = reg_wdata[CTRL4_STICKY_BIT];
				OFS_MISC:      next_st.l3_off = reg_wdata[MISC_L3_OFF_BIT];
				OFS_SYS_CFG: begin
					next_st.variant    = variant_t'(reg_wdata[CFG_VARIANT_LSB +: CFG_VARIANT_W]);
					next_st.dual       = reg_wdata[CFG_DUAL_BIT];
					next_st.l3_present = reg_wdata[CFG_L3_PRESENT_BIT];
				end
				default: begin
					if (range_sel) begin
						next_st.range[reg_addr[RANGE_IDX_LSB +: RANGE_IDX_W]] = reg_wdata;
					end
				end
			endcase
		end

		next_st.rdata = WORD_ZERO;
		if (reg_read) begin
			unique case (reg_addr)
				OFS_CTRL_ZERO: next_st.rdata = st.ctrl_zero;
				OFS_PAGE_BASE: begin
					next_st.rdata[PAGE_BASE_CO_BIT] = st.pb_cache_off;
					next_st.rdata[PAGE_BASE_WT_BIT] = st.pb_write_thru;
				end
				OFS_CTRL_FOUR: next_st.rdata[CTRL4_STICKY_BIT] = st.sticky_enable;
				OFS_MISC:      next_st.rdata[MISC_L3_OFF_BIT] = st.l3_off;
				OFS_SYS_CFG: begin
					next_st.rdata[CFG_VARIANT_LSB +: CFG_VARIANT_W] = st.variant;
					next_st.rdata[CFG_DUAL_BIT]       = st.dual;
					next_st.rdata[CFG_L3_PRESENT_BIT] = st.l3_present;
				end
				OFS_STATUS: begin
					next_st.rdata[STAT_MODE_LSB +: CFG_VARIANT_W]  = mode;
					next_st.rdata[STAT_ACCEPT_BIT]                 = snoop_accept;
					next_st.rdata[STAT_L1SNP_BIT]                  = l1_snoop_service;
					next_st.rdata[STAT_KEN_BIT]                    = st.ken_cacheable;
					next_st.rdata[STAT_WBSEL_BIT]                  = st.wb_select;
					next_st.rdata[STAT_TYPE_LSB +: RANGE_TYPE_W]   = st.eff_type;
					next_st.rdata[STAT_L3_BIT] = st.l3_present && !st.l3_off;
				end
				default: begin
					if (range_sel) begin
						next_st.rdata = st.range[reg_addr[RANGE_IDX_LSB +: RANGE_IDX_W]];
					end
				end
			endcase
		end

		// The first stage only feeds the second; a level counts once stages two and three agree.
		next_st.ken_sync = {st.ken_sync[1:0], !cacheable_access_input_n};
		next_st.wbs_sync = {st.wbs_sync[1:0], writeback_select_input};
		if (st.ken_sync[1] == st.ken_sync[2]) begin
			next_st.ken_cacheable = st.ken_sync[2];
		end
		if (st.wbs_sync[1] == st.wbs_sync[2]) begin
			next_st.wb_select = st.wbs_sync[2];
		end

		next_st.resp_valid = access_valid;
		if (access_valid) begin
			next_st.serve      = 1'b0;
			next_st.alloc      = 1'b0;
			next_st.update     = 1'b0;
			next_st.wmem       = 1'b0;
			next_st.next_state = access_line_state;
			next_st.eff_type   = (mode == MODE_DISABLED) ? MT_UC : eff;
			unique case (mode)
				MODE_DISABLED: begin
					next_st.wmem = access_write;
				end
				MODE_NONCOHERENT: begin
					if (line_present) begin
						next_st.serve  = !access_write;
						next_st.update = access_write;
						if (access_write && access_line_state == LINE_E) begin
							next_st.next_state = LINE_M;
						end
					end else begin
						next_st.wmem = access_write;
					end
				end
				MODE_NORMAL, MODE_NO_FILL: begin
					if (line_present && cacheable) begin
						next_st.serve  = !access_write;
						next_st.update = access_write && eff != MT_WP;
						if (access_write && eff == MT_WB && access_line_state != LINE_S) begin
							next_st.next_state = LINE_M;
						end else begin
							next_st.wmem = access_write;
						end
					end else begin
						// No-fill mode keeps coherency but never brings a new line in.
						next_st.alloc = mode == MODE_NORMAL && cacheable
							&& (!access_write || eff == MT_WB);
						next_st.wmem  = access_write && !next_st.alloc;
					end
				end
			endcase
			next_st.l3_alloc = next_st.alloc && st.l3_present && !st.l3_off;
			next_st.sticky_ok = pte_sticky && st.sticky_enable && paging;
			next_st.pin_cache_off  = sel_cache_off;
			next_st.pin_write_thru = sel_write_thru;
		end

		next_st.snoop_inval = snoop_valid && snoop_accept && l1_snoop_service
			&& snoop_hit && snoop_invalidating;
		next_st.snoop_outer = snoop_valid && snoop_accept;
		next_st.parity_err_n = !(snoop_valid && snoop_accept
			&& ((^snoop_addr) != snoop_addr_parity));
		next_st.discard     = discard_all_lines_op;
		next_st.wb_discard  = writeback_discard_op;
		next_st.flush_entry = tlb_flush_req && !(tlb_entry_sticky && st.sticky_enable);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st              <= '0;
			st.ctrl_zero    <= CTRL_ZERO_RESET;
			st.variant      <= VAR_OLDER;
			st.ken_sync     <= PIN_SYNC_RESET;
			st.wbs_sync     <= PIN_SYNC_RESET;
			st.next_state   <= LINE_I;
			st.eff_type     <= MT_UC;
			st.parity_err_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata               = st.rdata;
	assign resp_valid              = st.resp_valid;
	assign resp_serve_from_cache   = st.serve;
	assign resp_allocate           = st.alloc;
	assign resp_update_line        = st.update;
	assign resp_write_memory       = st.wmem;
	assign resp_next_state         = st.next_state;
	assign resp_mem_type           = st.eff_type;
	assign resp_l3_allocate        = st.l3_alloc;
	assign resp_sticky_ok          = st.sticky_ok;
	assign page_cache_off_pin      = st.pin_cache_off;
	assign page_write_thru_pin     = st.pin_write_thru;
	assign snoop_l1_invalidate     = st.snoop_inval;
	assign snoop_outer_forward     = st.snoop_outer;
	assign addr_parity_error_out_n = st.parity_err_n;
	assign l1_discard_all          = st.discard;
	assign l1_writeback_discard    = st.wb_discard;
	assign tlb_flush_entry         = st.flush_entry;
endmodule
`default_nettype wire

// File: src/cache_policy_pkg.sv
// Constants, field layouts and types shared by the cache policy control logic.
`default_nettype none
package cache_policy_pkg;
	localparam int REG_ADDR_W = 8;
	localparam int REG_DATA_W = 32;

	localparam logic [7:0] OFS_CTRL_ZERO  = 8'h00;
	localparam logic [7:0] OFS_PAGE_BASE  = 8'h04;
	localparam logic [7:0] OFS_CTRL_FOUR  = 8'h08;
	localparam logic [7:0] OFS_MISC       = 8'h0C;
	localparam logic [7:0] OFS_SYS_CFG    = 8'h10;
	localparam logic [7:0] OFS_STATUS     = 8'h14;
	localparam logic [3:0] RANGE_AREA_TAG = 4'h2;
	localparam int         RANGE_AREA_LSB = 4;
	localparam int         RANGE_IDX_LSB  = 2;
	localparam int         RANGE_IDX_W    = 2;
	localparam int         RANGE_COUNT    = 4;
	localparam logic [1:0] WORD_ALIGN     = 2'h0;

	localparam int CTRL0_PAGING_BIT       = 31;
	localparam int CTRL0_CACHE_OFF_BIT    = 30;
	localparam int CTRL0_WRITE_POLICY_BIT = 29;
	localparam int PAGE_BASE_WT_BIT       = 3;
	localparam int PAGE_BASE_CO_BIT       = 4;
	localparam int CTRL4_STICKY_BIT       = 7;
	localparam int MISC_L3_OFF_BIT        = 6;
	localparam int CFG_VARIANT_LSB        = 0;
	localparam int CFG_VARIANT_W          = 2;
	localparam int CFG_DUAL_BIT           = 4;
	localparam int CFG_L3_PRESENT_BIT     = 5;
	localparam int RANGE_TYPE_LSB         = 0;
	localparam int RANGE_TYPE_W           = 3;
	localparam int RANGE_VALID_BIT        = 3;
	localparam int RANGE_BASE_LSB         = 16;
	localparam int RANGE_BASE_W           = 16;

	localparam int STAT_MODE_LSB    = 0;
	localparam int STAT_ACCEPT_BIT  = 2;
	localparam int STAT_L1SNP_BIT   = 3;
	localparam int STAT_KEN_BIT     = 4;
	localparam int STAT_WBSEL_BIT   = 5;
	localparam int STAT_TYPE_LSB    = 8;
	localparam int STAT_L3_BIT      = 11;

	localparam logic [31:0] CTRL_ZERO_RESET = 32'h6000_0000;
	localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
	localparam logic [2:0]  PIN_SYNC_RESET  = 3'h0;

	typedef enum logic [2:0] {
		MT_UC = 3'h0,
		MT_WC = 3'h1,
		MT_WT = 3'h2,
		MT_WP = 3'h3,
		MT_WB = 3'h4
	} mem_type_t;

	localparam mem_type_t RANGE_DEFAULT_TYPE = MT_WB;

	typedef enum logic [1:0] {VAR_OLDER, VAR_NEWER, VAR_LOW_POWER} variant_t;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_NO_FILL, MODE_NONCOHERENT, MODE_DISABLED}
		cache_mode_t;
	typedef enum logic [1:0] {LINE_I, LINE_S, LINE_E, LINE_M} line_state_t;
endpackage
`default_nettype wire

// File: src/policy_if.sv
// Interface carrying page flags and range type into the memory-type combiner.
`default_nettype none
interface policy_if;
	import cache_policy_pkg::*;
	mem_type_t range_type;
	logic      page_cache_off;
	logic      page_write_thru;
	logic      cache_off_applies;
	logic      write_thru_applies;
	mem_type_t eff_type;
	modport requester (output range_type, page_cache_off, page_write_thru,
		cache_off_applies, write_thru_applies, input eff_type);
	modport combiner (input range_type, page_cache_off, page_write_thru,
		cache_off_applies, write_thru_applies, output eff_type);
endinterface
`default_nettype wire

// File: src/mem_type_combiner.sv
// Merges the page-level flags with the range-table type into one memory type.
`default_nettype none
module mem_type_combiner
	import cache_policy_pkg::*;
(
	policy_if.combiner pif
);
	logic page_blocks;
	logic page_thru;

	always_comb begin
		page_blocks = pif.page_cache_off & pif.cache_off_applies;
		page_thru   = pif.page_write_thru & pif.write_thru_applies;
		// Uncached from either side always wins, so neither can re-enable the other.
		if (page_blocks || pif.range_type == MT_UC) begin
			pif.eff_type = MT_UC;
		end else if (pif.range_type == MT_WC) begin
			pif.eff_type = MT_WC;
		end else if (pif.range_type == MT_WP) begin
			pif.eff_type = MT_WP;
		end else if (page_thru || pif.range_type == MT_WT) begin
			pif.eff_type = MT_WT;
		end else begin
			pif.eff_type = MT_WB;
		end
	end
endmodule
`default_nettype wire

// File: dv/cache_policy_monitor.sv
// Port-level checks on the cache policy control block.
`default_nettype none
module cache_policy_monitor
	import cache_policy_pkg::*;
(
	input wire logic        core_clk, srst, access_valid, access_dir, pte_cache_off,
	input wire logic        resp_valid, resp_allocate, resp_write_memory, page_cache_off_pin,
	input wire logic        discard_all_lines_op, l1_discard_all, writeback_discard_op,
	input wire logic        l1_writeback_discard, snoop_valid, snoop_addr_parity, snoop_hit,
	input wire logic        snoop_invalidating, snoop_l1_invalidate, snoop_outer_forward,
	input wire logic        addr_parity_error_out_n, tlb_flush_req, tlb_flush_entry,
	input wire logic [31:0] snoop_addr,
	input wire cache_policy_pkg::mem_type_t resp_mem_type
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_resp; resp_valid == $past(access_valid); endproperty
	a_resp: assert property (p_resp) else $error("late response");
	property p_disc; discard_all_lines_op |=> l1_discard_all; endproperty
	a_disc: assert property (p_disc) else $error("discard lost");
	property p_wbd; writeback_discard_op |=> l1_writeback_discard; endproperty
	a_wbd: assert property (p_wbd) else $error("writeback discard lost");
	property p_inv;
		snoop_l1_invalidate |-> $past(snoop_valid && snoop_hit && snoop_invalidating);
	endproperty
	a_inv: assert property (p_inv) else $error("stray invalidate");
	property p_par;
		!addr_parity_error_out_n |-> $past(snoop_valid && ((^snoop_addr) != snoop_addr_parity));
	endproperty
	a_par: assert property (p_par) else $error("stray parity error");
	property p_fwd; snoop_outer_forward |-> $past(snoop_valid); endproperty
	a_fwd: assert property (p_fwd) else $error("stray forward");
	property p_pin;
		access_valid && !access_dir |=> page_cache_off_pin == $past(pte_cache_off);
	endproperty
	a_pin: assert property (p_pin) else $error("page pin wrong");
	property p_alloc;
		resp_valid && resp_allocate |-> !(resp_mem_type inside {MT_UC, MT_WC}) && !resp_write_memory;
	endproperty
	a_alloc: assert property (p_alloc) else $error("allocate of uncached");
	property p_tlb; tlb_flush_entry |-> $past(tlb_flush_req); endproperty
	a_tlb: assert property (p_tlb) else $error("stray flush");
endmodule
bind cache_mode_policy_control cache_policy_monitor u_cache_policy_monitor(.*);
`default_nettype wire

// File: dv/bus_far_end.sv
// Far side model: area pins of the external memory decoder and a snooping agent.
`default_nettype none
module bus_far_end (
	input  wire logic        core_clk,
	output logic             cacheable_access_input_n,
	output logic             writeback_select_input,
	output logic             snoop_valid,
	output logic      [31:0] snoop_addr,
	output logic             snoop_addr_parity,
	output logic             snoop_hit,
	output logic             snoop_invalidating
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] SNOOP_AREA = 32'h0001_2340;
	initial begin
		cacheable_access_input_n = 1'b1;
		writeback_select_input = 1'b0;
		{snoop_valid, snoop_addr, snoop_addr_parity, snoop_hit, snoop_invalidating} = '0;
	end
	task automatic set_area(input logic not_cacheable, input logic write_back);
		@(posedge core_clk);
		cacheable_access_input_n <= not_cacheable;
		writeback_select_input <= write_back;
	endtask
	// The address bus is inverted once released, so stale values never look valid.
	task automatic snoop(input logic bad_parity);
		@(posedge core_clk);
		snoop_valid <= 1'b1;
		snoop_addr <= SNOOP_AREA;
		snoop_addr_parity <= (^SNOOP_AREA) ^ bad_parity;
		{snoop_hit, snoop_invalidating} <= 2'h3;
		@(posedge core_clk);
		snoop_valid <= 1'b0;
		snoop_addr <= ~SNOOP_AREA;
		snoop_addr_parity <= !snoop_addr_parity;
		{snoop_hit, snoop_invalidating} <= 2'h0;
	endtask
endmodule
`default_nettype wire

// File: dv/test_cache_mode_policy_control.sv
// Self-checking testbench for the cache policy control block.
`default_nettype none
module test_cache_mode_policy_control;
	timeunit 1ns;
	timeprecision 1ps;
	import cache_policy_pkg::*;
	logic core_clk, srst, reg_write, reg_read, access_valid, access_write, access_dir;
	logic access_hit, pte_cache_off, pte_write_thru, pte_sticky, discard_all_lines_op;
	logic writeback_discard_op, tlb_flush_req, tlb_entry_sticky, resp_valid;
	logic resp_serve_from_cache, resp_allocate, resp_update_line, resp_write_memory;
	logic resp_l3_allocate, resp_sticky_ok, page_cache_off_pin, page_write_thru_pin;
	logic snoop_l1_invalidate, snoop_outer_forward, addr_parity_error_out_n, l1_discard_all;
	logic l1_writeback_discard, tlb_flush_entry, cacheable_access_input_n;
	logic writeback_select_input, snoop_valid, snoop_addr_parity, snoop_hit, snoop_invalidating;
	logic        [7:0]  reg_addr;
	logic        [31:0] reg_wdata, reg_rdata, access_addr, snoop_addr;
	line_state_t        access_line_state, resp_next_state;
	mem_type_t          resp_mem_type;
	int                 fail_count, checks;
	cache_mode_policy_control u_cache_mode_policy_control(.*);
	bus_far_end u_bus_far_end(.*);
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m, e);
		@(posedge core_clk);
		{reg_read, reg_addr} <= {1'b1, a};
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1 chk(n, e, reg_rdata & m);
	endtask
	// Result word: serve, allocate, update, memory write, next state, memory type.
	task automatic acc(input logic w, h, input line_state_t s, input logic [8:0] e, m);
		@(posedge core_clk);
		{access_valid, access_write, access_hit, access_line_state} <= {1'b1, w, h, s};
		@(posedge core_clk);
		access_valid <= 1'b0;
		#1 chk("resp", e & m, {resp_serve_from_cache, resp_allocate, resp_update_line,
			resp_write_memory, resp_next_state, resp_mem_type} & m);
	endtask
	task automatic pl(input logic [2:0] e);
		@(posedge core_clk);
		{discard_all_lines_op, writeback_discard_op, tlb_flush_req} <= 3'h7;
		@(posedge core_clk);
		{discard_all_lines_op, writeback_discard_op, tlb_flush_req} <= 3'h0;
		#1 chk("pulse", e, {l1_discard_all, l1_writeback_discard, tlb_flush_entry});
	endtask
	task automatic snp(input logic bad, input logic [2:0] e);
		u_bus_far_end.snoop(bad);
		#1 chk("snoop", e, {snoop_outer_forward, snoop_l1_invalidate, addr_parity_error_out_n});
	endtask
	task automatic complete_run;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		complete_run;
	end
	initial begin
		{reg_write, reg_read, access_valid, access_write, access_dir, access_hit} = '0;
		{pte_cache_off, pte_write_thru, pte_sticky, tlb_entry_sticky} = '0;
		{discard_all_lines_op, writeback_discard_op, tlb_flush_req} = '0;
		{reg_addr, reg_wdata, access_addr} = '0;
		access_line_state = LINE_I;
		srst = 1'b1;
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		rdc("ctrl0", OFS_CTRL_ZERO, '1, CTRL_ZERO_RESET);
		rdc("mode", OFS_STATUS, 32'h3, 32'h2);
		rdc("unmapped", 8'h3C, '1, 32'h0);
		acc(0, 1, LINE_E, 9'h100, 9'h1E0);
		acc(0, 0, LINE_I, 9'h000, 9'h1E0);
		acc(1, 1, LINE_E, 9'h058, 9'h058);
		acc(1, 1, LINE_S, 9'h048, 9'h058);
		acc(1, 0, LINE_I, 9'h020, 9'h0A0);
		pl(3'h7);
		snp(1, 3'h1);
		wr(OFS_SYS_CFG, 32'h10);
		snp(1, 3'h4);
		wr(OFS_CTRL_ZERO, 32'h0);
		snp(0, 3'h7);
		for (int i = 0; i < 3; i++) begin
			u_bus_far_end.set_area(i[1], !i[0]);
			repeat (6) @(posedge core_clk);
			acc(0, 0, LINE_I, 9'(4 - 2 * i), 9'h007);
		end
		wr(OFS_SYS_CFG, 32'h1);
		for (int i = 0; i < 2; i++) begin
			wr(OFS_CTRL_ZERO, (i == 0) ? 32'h4000_0000 : 32'h6000_0000);
			rdc("mode", OFS_STATUS, 32'h3, 32'h1);
			acc(0, 0, LINE_I, 9'h000, 9'h180);
		end
		wr(OFS_SYS_CFG, 32'h2);
		rdc("mode", OFS_STATUS, 32'h3, 32'h3);
		acc(0, 1, LINE_E, 9'h000, 9'h187);
		wr(OFS_SYS_CFG, 32'h21);
		wr(OFS_CTRL_ZERO, 32'h8000_0000);
		acc(0, 0, LINE_I, 9'h084, 9'h1E7);
		chk("l3", 1, resp_l3_allocate);
		wr(OFS_MISC, 32'h40);
		acc(0, 0, LINE_I, 9'h084, 9'h1E7);
		chk("l3", 0, resp_l3_allocate);
		pte_cache_off <= 1'b1;
		acc(0, 0, LINE_I, 9'h000, 9'h187);
		{pte_cache_off, pte_write_thru} <= 2'h1;
		acc(0, 0, LINE_I, 9'h082, 9'h187);
		chk("wt pin", 1, page_write_thru_pin);
		acc(1, 0, LINE_I, 9'h022, 9'h0A7);
		wr(OFS_CTRL_ZERO, 32'hA000_0000);
		acc(0, 0, LINE_I, 9'h004, 9'h007);
		wr(OFS_CTRL_ZERO, 32'h0);
		{pte_cache_off, pte_write_thru} <= 2'h2;
		acc(0, 0, LINE_I, 9'h004, 9'h007);
		chk("pin", 1, page_cache_off_pin);
		pte_cache_off <= 1'b0;
		wr(OFS_CTRL_ZERO, 32'h8000_0000);
		access_addr <= 32'h0001_0000;
		for (int t = 0; t < 5; t++) begin
			wr(8'h20, 32'h0001_0008 | t);
			acc(0, 0, LINE_I, 9'(t), 9'h007);
		end
		wr(OFS_PAGE_BASE, 32'h10);
		access_dir <= 1'b1;
		acc(0, 0, LINE_I, 9'h000, 9'h007);
		chk("pin", 1, page_cache_off_pin);
		access_dir <= 1'b0;
		acc(0, 0, LINE_I, 9'h004, 9'h007);
		wr(OFS_CTRL_FOUR, 32'h80);
		{pte_sticky, tlb_entry_sticky} <= 2'h3;
		acc(0, 0, LINE_I, 9'h004, 9'h007);
		chk("sticky", 1, resp_sticky_ok);
		pl(3'h6);
		wr(OFS_CTRL_FOUR, 32'h0);
		pl(3'h7);
		complete_run;
	end
endmodule
`default_nettype wire
